/* isar_master_model.sv */
// Behavioural bus master on the link clock.
// Pulls SCL/SDA low through enables; the bench resolves wires with pull-ups.
module isar_master_model (
  input wire logic clk_link,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow phases so the slave's synchronisers see every edge in order
  localparam int HALF = 20;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  ////////////////////////////////////////
  task automatic half();
    repeat (HALF) @(posedge clk_link);
  endtask
  // Release SCL and wait out slave stretching, bounded
  task automatic rise();
    int n;
    n = 0;
    scl_oe = 1'b0;
    @(posedge clk_link);
    while (!scl_i && n < 20000) begin
      @(posedge clk_link);
      n++;
    end
    half();
  endtask
  task automatic fall();
    scl_oe = 1'b1;
    // SDA moves only well after SCL is low, never racing it
    repeat (8) @(posedge clk_link);
  endtask
  task automatic start();
    sda_oe = 1'b0;
    half();
    rise();
    sda_oe = 1'b1;
    half();
    fall();
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    half();
    rise();
    sda_oe = 1'b0;
    half();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe = !b[i];
      half();
      rise();
      fall();
    end
    sda_oe = 1'b0;
    half();
    rise();
    ack = !sda_i;
    fall();
  endtask
endmodule

/* isar_pkg.sv */
// Constants and carrier types for the two-wire slave address/receive block.
// Assumes a single system clock; software-side controls arrive as plain ports.
package isar_pkg;

  // Slave mode codes of the port mode select field
  localparam logic [3:0] MODE_7BIT = 4'h6;
  localparam logic [3:0] MODE_10BIT = 4'h7;
  localparam logic [3:0] MODE_7BIT_SS = 4'he;
  localparam logic [3:0] MODE_10BIT_SS = 4'hf;

  // High address byte prefix in 10-bit addressing
  localparam logic [4:0] HI_PREFIX = 5'h1e;
  localparam int A98_LSB = 1;

  // Bit counter values for the 8th and 9th falling SCL edges
  localparam logic [3:0] CNT_FALL8 = 4'h7;
  localparam logic [3:0] CNT_FALL9 = 4'h8;

  localparam logic [7:0] BUF_RESET = 8'h00;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_ADDR_LO = 4'b0100,
    PH_DATA = 4'b1000
  } isar_phase_type;

  typedef struct packed {
    logic [3:0] port_mode_select;
    logic start_irq_enable;
    logic stop_irq_enable;
    logic address_hold_enable;
    logic data_hold_enable;
    logic ack_data_bit;
    logic buffer_override_enable;
    logic stretch_enable;
    logic [7:0] slave_address_register;
    logic [7:0] address_mask_register;
  } isar_ctrl_type;

  typedef struct packed {
    logic clock_release_set;
    logic address_write;
    logic irq_clear;
    logic buffer_read;
    logic overflow_clear;
    logic start_seen_clear;
  } isar_strobe_type;

  typedef struct packed {
    logic [7:0] receive_buffer;
    logic buffer_full_flag;
    logic receive_overflow_flag;
    logic port_interrupt_flag;
    logic ack_status_bit;
    logic ack_time_status;
    logic update_address_flag;
    logic start_seen;
    logic stop_seen;
    logic read_write_bit;
    logic data_not_address;
    logic clock_release_bit;
  } isar_status_type;

endpackage

/* isar_slave.sv */
// Two-wire slave: start/stop detection, address match, byte reception.
// Assumes open-drain SCL/SDA resolved outside; software strobes are
// one-cycle pulses on clk_sys.
module isar_slave (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input isar_pkg::isar_ctrl_type ctrl,
  input isar_pkg::isar_strobe_type stb,
  output isar_pkg::isar_status_type status
);
  import isar_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: bits shift in on rising SCL, MSB first
  logic [7:0] shift_q;

  // Data path only; stale bits are overwritten before any byte completes
  always_ff @(posedge scl_i) begin
    shift_q <= {shift_q[6:0], sda_i};
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic start_det;
  logic stop_det;
  logic low_seen_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], scl_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
    end
  end

  assign scl_rise = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall = ~scl_sync_r[1] & scl_sync_r[2];
  assign sda_rise = sda_sync_r[1] & ~sda_sync_r[2];
  assign sda_fall = ~sda_sync_r[1] & sda_sync_r[2];

  function automatic logic is_slave_mode(input logic [3:0] m);
    return (m == MODE_7BIT) || (m == MODE_10BIT) ||
           (m == MODE_7BIT_SS) || (m == MODE_10BIT_SS);
  endfunction

  function automatic logic has_ss_irq(input logic [3:0] m);
    return (m == MODE_7BIT_SS) || (m == MODE_10BIT_SS);
  endfunction

  logic slave_on;
  logic ss_mode;
  logic ten_bit;
  assign slave_on = is_slave_mode(ctrl.port_mode_select);
  assign ss_mode = has_ss_irq(ctrl.port_mode_select);
  assign ten_bit = ctrl.port_mode_select[0];

  // Start/restart and stop need SCL high on both samples
  assign start_det = slave_on & sda_fall & scl_sync_r[1] & scl_sync_r[2];
  assign stop_det = slave_on & sda_rise & scl_sync_r[1] & scl_sync_r[2] &
                    low_seen_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_seen_r <= 1'b0;
    end else if (start_det) begin
      low_seen_r <= 1'b0;
    end else if (scl_fall) begin
      low_seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte framing
  isar_phase_type phase_r;
  logic [3:0] bit_cnt_r;
  logic fall8;
  logic fall9;
  logic rise9;

  assign fall8 = scl_fall & (bit_cnt_r == CNT_FALL8) & (phase_r != PH_IDLE);
  assign fall9 = scl_fall & (bit_cnt_r == CNT_FALL9) & (phase_r != PH_IDLE);
  assign rise9 = scl_rise & (bit_cnt_r == CNT_FALL9) & (phase_r != PH_IDLE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_cnt_r <= 4'h0;
    end else if (start_det) begin
      bit_cnt_r <= 4'h0;
    end else if (fall9) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_fall && low_seen_r && phase_r != PH_IDLE) begin
      // The SCL fall that closes a start is not a data bit, so it is skipped
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode at the eighth falling edge
  // The shifter is quiet from the 8th rise to the 9th rise, so it is
  // stable here although it lives on the link clock.
  logic [7:0] rx_byte;
  logic full_match_r;
  logic match7;
  logic match_hi;
  logic match_lo;
  logic accept;
  logic blocked;
  logic hold;
  logic sw_ack;
  assign rx_byte = shift_q;

  assign match7 = ~|((rx_byte[7:1] ^ ctrl.slave_address_register[7:1]) &
                     ctrl.address_mask_register[7:1]);
  assign match_hi = (rx_byte[7:3] == HI_PREFIX) &&
                    (rx_byte[2:1] == ctrl.slave_address_register[A98_LSB+1:A98_LSB]) &&
                    (!rx_byte[0] || full_match_r);
  assign match_lo = ~|((rx_byte ^ ctrl.slave_address_register) &
                       ctrl.address_mask_register);

  always_comb begin
    unique case (phase_r)
      PH_ADDR: accept = ten_bit ? match_hi : match7;
      PH_ADDR_LO: accept = match_lo;
      PH_DATA: accept = 1'b1;
      default: accept = 1'b0;
    endcase
  end

  // Override still refuses once overflow is already latched
  assign blocked = status.receive_overflow_flag |
                   (status.buffer_full_flag & ~ctrl.buffer_override_enable);
  assign hold = accept & ((phase_r == PH_DATA) ? ctrl.data_hold_enable :
                ctrl.address_hold_enable);
  assign sw_ack = ctrl.address_hold_enable & ctrl.data_hold_enable;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_r <= PH_IDLE;
    end else if (start_det) begin
      phase_r <= PH_ADDR;
    end else if (stop_det) begin
      phase_r <= PH_IDLE;
    end else if (fall8) begin
      if (!accept) begin
        phase_r <= PH_IDLE;
      end else if (phase_r == PH_ADDR && rx_byte[0]) begin
        phase_r <= PH_IDLE; // Read requests: transmit side not built here
      end else if (phase_r == PH_ADDR && ten_bit) begin
        phase_r <= PH_ADDR_LO;
      end else begin
        phase_r <= PH_DATA;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      full_match_r <= 1'b0;
    end else if (stop_det) begin
      full_match_r <= 1'b0;
    end else if (fall8 && phase_r == PH_ADDR_LO) begin
      full_match_r <= match_lo;
    end else if (fall8 && phase_r == PH_ADDR && ten_bit && (!match_hi || !rx_byte[0])) begin
      full_match_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge slot
  logic ack_slot_r;
  logic ack_val_r;
  logic ua_pend_r;
  logic lo_pend_r;
  logic read_pend_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_slot_r <= 1'b0;
      ack_val_r <= 1'b0;
    end else if (start_det || stop_det || fall9) begin
      ack_slot_r <= 1'b0;
    end else if (fall8) begin
      ack_slot_r <= accept;
      // Under software ack SDA stays free until the release picks a value
      ack_val_r <= sw_ack ? 1'b0 : ~blocked;
    end else if (stb.clock_release_set && status.ack_time_status && sw_ack) begin
      ack_val_r <= ~ctrl.ack_data_bit;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = ack_slot_r & ack_val_r;
  assign scl_o = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ua_pend_r <= 1'b0;
      lo_pend_r <= 1'b0;
      read_pend_r <= 1'b0;
    end else if (start_det || stop_det || fall9) begin
      ua_pend_r <= 1'b0;
      lo_pend_r <= 1'b0;
      read_pend_r <= 1'b0;
    end else if (fall8) begin
      ua_pend_r <= (phase_r == PH_ADDR_LO) ||
                   (phase_r == PH_ADDR && ten_bit && accept && !rx_byte[0]);
      lo_pend_r <= phase_r == PH_ADDR_LO;
      read_pend_r <= (phase_r == PH_ADDR) && accept && rx_byte[0];
    end
  end

  logic acked9;
  assign acked9 = fall9 & ack_slot_r & ack_val_r;

  ////////////////////////////////////////////////////////////////////////
  // Clock stretching; a set in the same cycle as a release wins
  logic stretch_r;
  logic stretch_set;
  assign stretch_set = (fall8 & hold) |
                       (acked9 & (ctrl.stretch_enable | read_pend_r)) |
                       (fall9 & ua_pend_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stretch_r <= 1'b0;
    end else if (stretch_set) begin
      stretch_r <= 1'b1;
    end else if (status.update_address_flag ? stb.address_write : stb.clock_release_set) begin
      stretch_r <= 1'b0;
    end
  end

  assign scl_oe = stretch_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.update_address_flag <= 1'b0;
    end else if (fall9 && ua_pend_r) begin
      status.update_address_flag <= 1'b1;
    end else if (stb.address_write) begin
      status.update_address_flag <= 1'b0;
    end
  end

  assign status.clock_release_bit = ~stretch_r;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flag
  logic irq_set;
  logic start_irq;
  logic stop_irq;
  assign start_irq = start_det & (ss_mode | ctrl.start_irq_enable);
  assign stop_irq = stop_det & (ss_mode | ctrl.stop_irq_enable);
  assign irq_set = start_irq | stop_irq | (fall8 & hold) | acked9 |
                   (fall9 & lo_pend_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.port_interrupt_flag <= 1'b0;
    end else if (irq_set) begin
      status.port_interrupt_flag <= 1'b1;
    end else if (stb.irq_clear) begin
      status.port_interrupt_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer and its flags
  logic load;
  assign load = fall8 & accept & ~blocked;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.receive_buffer <= BUF_RESET;
      status.data_not_address <= 1'b0;
      status.read_write_bit <= 1'b0;
    end else if (load) begin
      status.receive_buffer <= rx_byte;
      status.data_not_address <= phase_r == PH_DATA;
      if (phase_r == PH_ADDR) begin
        status.read_write_bit <= rx_byte[0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.buffer_full_flag <= 1'b0;
    end else if (load) begin
      status.buffer_full_flag <= 1'b1;
    end else if (stb.buffer_read) begin
      status.buffer_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.receive_overflow_flag <= 1'b0;
    end else if (fall8 && accept && status.buffer_full_flag) begin
      status.receive_overflow_flag <= 1'b1;
    end else if (stb.overflow_clear) begin
      status.receive_overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus status bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.ack_status_bit <= 1'b0;
    end else if (rise9) begin
      status.ack_status_bit <= sda_sync_r[1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.ack_time_status <= 1'b0;
    end else if (fall8 && accept &&
                 (ctrl.address_hold_enable || ctrl.data_hold_enable)) begin
      status.ack_time_status <= 1'b1;
    end else if (fall9 || start_det || stop_det) begin
      status.ack_time_status <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status.start_seen <= 1'b0;
      status.stop_seen <= 1'b0;
    end else if (start_det) begin
      status.start_seen <= 1'b1;
      status.stop_seen <= 1'b0;
    end else if (stop_det) begin
      status.stop_seen <= 1'b1;
      status.start_seen <= 1'b0;
    end else if (stb.start_seen_clear) begin
      status.start_seen <= 1'b0;
    end
  end

endmodule

/* isar_slave_asserts.sv */
// Port-level checks for the two-wire slave.
// Bound to isar_slave; sees only its ports, single clk_sys domain.
module isar_slave_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input isar_pkg::isar_ctrl_type ctrl,
  input isar_pkg::isar_strobe_type stb,
  input isar_pkg::isar_status_type status
);
  import isar_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_reset_quiet: assert property ($fell(rst) |-> !scl_oe && !sda_oe && status == 19'h00001)
    else $error("outputs not quiet after reset");
  chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  chk_ack_blocked: assert property ($rose(sda_oe) && !ctrl.address_hold_enable && !ctrl.data_hold_enable
    |-> !$past(status.receive_overflow_flag) && (ctrl.buffer_override_enable || !$past(status.buffer_full_flag)))
    else $error("ack given while blocked");
  chk_ack_loads: assert property ($rose(sda_oe) && !ctrl.address_hold_enable |-> status.buffer_full_flag)
    else $error("ack without loaded buffer");
  chk_sw_ack: assert property (stb.clock_release_set && status.ack_time_status && ctrl.address_hold_enable
    && ctrl.data_hold_enable |-> ##[1:3] (sda_oe == !ctrl.ack_data_bit))
    else $error("software ack not honoured");
  chk_acktime_hold: assert property (status.ack_time_status |-> ctrl.address_hold_enable || ctrl.data_hold_enable)
    else $error("ack time without hold");
  chk_irq_sticky: assert property (status.port_interrupt_flag && !stb.irq_clear |=> status.port_interrupt_flag)
    else $error("interrupt flag dropped");
  chk_read_clears: assert property (stb.buffer_read |=> !status.buffer_full_flag || $rose(sda_oe)
    || $rose(status.ack_time_status))
    else $error("buffer read left full flag");
  chk_stretch_free: assert property (scl_oe && stb.clock_release_set && !status.update_address_flag
    |-> ##[1:3] !scl_oe)
    else $error("clock not released");
  chk_ua_stretch: assert property ($rose(status.update_address_flag) |-> ##[0:3] scl_oe)
    else $error("no stretch with update flag");
  chk_ua_clear: assert property (status.update_address_flag && stb.address_write |=> !status.update_address_flag)
    else $error("update flag not cleared");
  cov_ack: cover property ($rose(sda_oe));
  cov_update: cover property ($rose(status.update_address_flag));
  cov_overflow: cover property ($rose(status.receive_overflow_flag));
endmodule

bind isar_slave isar_slave_asserts u_isar_slave_asserts (.clk_sys(clk_sys), .rst(rst), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .ctrl(ctrl),
  .stb(stb), .status(status));

/* isar_slave_tb.sv */
// Self-checking bench for the two-wire slave address/receive block.
// Master model runs on a 12 ns link clock; software side driven on falling clk_sys.
module isar_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isar_pkg::*;
  typedef struct packed {
    logic [3:0] mode;
    logic [7:0] sadr;
    logic [7:0] mask;
    logic [7:0] sent;
    logic ack;
    logic sie;
  } isar_tb_row_type;
  logic clk_sys, clk_link, rst, scl, sda, d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe, ack;
  isar_ctrl_type ctrl;
  isar_strobe_type stb;
  isar_status_type status;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  isar_tb_row_type rows [5] = '{
    '{MODE_7BIT, 8'ha0, 8'hff, 8'ha0, 1'b1, 1'b0},
    '{MODE_7BIT, 8'ha1, 8'hff, 8'ha0, 1'b1, 1'b0},
    '{MODE_7BIT, 8'ha0, 8'hff, 8'hb0, 1'b0, 1'b1},
    '{MODE_7BIT, 8'ha0, 8'hef, 8'hb0, 1'b1, 1'b0},
    '{MODE_7BIT_SS, 8'h42, 8'hff, 8'h40, 1'b0, 1'b0}};
  assign scl = ~(d_scl_oe | m_scl_oe);
  assign sda = ~(d_sda_oe | m_sda_oe);
  isar_slave u_isar_slave (.clk_sys(clk_sys), .rst(rst), .scl_i(scl), .scl_o(), .scl_oe(d_scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(d_sda_oe), .ctrl(ctrl), .stb(stb), .status(status));
  isar_master_model u_isar_master_model (.clk_link(clk_link), .scl_i(scl), .sda_i(sda),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3.7;
    forever #6 clk_link = ~clk_link;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [5:0] s);
    @(negedge clk_sys);
    stb = isar_strobe_type'(s);
    @(negedge clk_sys);
    stb = '0;
  endtask
  task automatic cfg(input logic [3:0] m, input logic [7:0] a, input logic [7:0] k,
      input logic [4:0] en);
    @(negedge clk_sys);
    ctrl = '0;
    ctrl.port_mode_select = m;
    ctrl.slave_address_register = a;
    ctrl.address_mask_register = k;
    {ctrl.address_hold_enable, ctrl.data_hold_enable, ctrl.ack_data_bit, ctrl.stretch_enable,
      ctrl.start_irq_enable} = en;
    pulse(6'h0f);
  endtask
  // Poll stretch (0) or update flag (1) on the falling edge, bounded
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    while (!(sel == 0 ? d_scl_oe : status.update_address_flag) && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(n < 4000), 32'h1);
  endtask
  // Software side of a stretched byte: check, read buffer, release clock
  task automatic serve(input logic [7:0] exp_buf, input logic exp_at);
    wait_on(0);
    chk(status.receive_buffer, exp_buf);
    chk(status.ack_time_status, exp_at);
    pulse(6'h04);
    pulse(6'h20);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ctrl = '0;
    stb = '0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    foreach (rows[i]) begin
      cfg(rows[i].mode, rows[i].sadr, rows[i].mask, {4'h0, rows[i].sie});
      u_isar_master_model.start();
      chk(status.start_seen, 1'b1);
      u_isar_master_model.put_byte(rows[i].sent, ack);
      chk(ack, rows[i].ack);
      chk(status.buffer_full_flag, rows[i].ack);
      if (rows[i].ack) chk(status.receive_buffer, rows[i].sent);
      u_isar_master_model.stop();
      chk(status.stop_seen, 1'b1);
      chk(status.port_interrupt_flag, rows[i].ack | rows[i].sie | rows[i].mode[3]);
    end
    $display("test rows done");
    cfg(MODE_7BIT, 8'ha0, 8'hff, 5'h00);
    u_isar_master_model.start();
    u_isar_master_model.put_byte(8'ha0, ack);
    u_isar_master_model.put_byte(8'h5c, ack);
    chk(ack, 1'b0);
    chk({status.receive_overflow_flag, status.receive_buffer}, 9'h1a0);
    pulse(6'h06);
    u_isar_master_model.start();
    u_isar_master_model.put_byte(8'ha0, ack);
    chk(ack, 1'b1);
    u_isar_master_model.stop();
    $display("test overflow done");
    cfg(MODE_7BIT, 8'ha0, 8'hff, 5'h02);
    u_isar_master_model.start();
    fork
      u_isar_master_model.put_byte(8'ha0, ack);
      serve(8'ha0, 1'b0);
    join
    chk(ack, 1'b1);
    fork
      u_isar_master_model.put_byte(8'h5c, ack);
      serve(8'h5c, 1'b0);
    join
    chk({ack, status.data_not_address, status.ack_status_bit}, 3'h6);
    u_isar_master_model.stop();
    $display("test stretch done");
    for (int k = 1; k >= 0; k--) begin
      cfg(MODE_7BIT, 8'ha0, 8'hff, {2'h3, k[0], 2'h0});
      u_isar_master_model.start();
      fork
        u_isar_master_model.put_byte(8'ha0, ack);
        serve(8'ha0, 1'b1);
      join
      chk({ack, status.ack_status_bit}, {!k[0], k[0]});
      u_isar_master_model.stop();
    end
    $display("test software ack done");
    cfg(MODE_10BIT_SS, 8'h04, 8'hff, 5'h00);
    u_isar_master_model.start();
    for (int k = 0; k < 2; k++) begin
      fork
        u_isar_master_model.put_byte(k == 0 ? 8'hf4 : 8'h3c, ack);
        begin
          wait_on(1);
          @(negedge clk_sys);
          ctrl.slave_address_register = k == 0 ? 8'h3c : 8'h04;
          pulse(6'h14);
        end
      join
      chk(ack, 1'b1);
    end
    chk({status.update_address_flag, status.port_interrupt_flag}, 2'h1);
    u_isar_master_model.stop();
    $display("test ten bit done");
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    chk({status, d_scl_oe, d_sda_oe}, 21'h4);
    $display("test reset done");
    summarize();
  end
endmodule
